// ===== core/trs_ref_switch.sv
// reference selection, failure masking, restore delay and register slave of the transmit loop
// Summary of operation
// - Bits 3:0 of the failure mask gate cycle, coarse, guard soak and precise indicators for switching.
// - Bits 7:4 gate the same four indicators, same order, for entry into holdover.
// - A mask bit of 0 ignores its indicator and a 1 lets it take effect.
// - A failed input becomes available again only after staying fault free for 0 to 15 minutes.
// - Bits 4:0 of the revert register give each input n its revertive enable.
// - Input 0 rank sits in bits 3:0 and input 1 rank in bits 7:4, used only in automatic mode.
// - Rank 0000 is highest and larger codes rank lower.
// - Input 1 with rank 1111 is never chosen automatically.
// - Automatic mode picks the best qualified input, moves on when it fails, holds over when none is left.
// - The selector is written by software in manual normal mode only and reports the choice in automatic mode.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module trs_ref_switch
    import trs_pkg::*;
#(
    parameter logic [31:0] P_MINUTE_CYCLES = 32'(MINUTE_CYCLES)
)
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [4:0]  i_cycle_monitor_fail,
    input  wire logic [4:0]  i_coarse_freq_monitor_fail,
    input  wire logic [4:0]  i_guard_soak_timer_fail,
    input  wire logic [4:0]  i_precise_freq_monitor_fail,
    output logic      [3:0]  o_selected_input,
    output logic             o_locked,
    output logic             o_holdover,
    output logic             o_freeze_estimate,
    output logic             o_freerun,
    output logic             o_external_control
);

    localparam int unsigned N = NUM_INPUTS;

    function automatic logic flag_hit(input logic [3:0] flags, input logic [3:0] mask);
        return |(flags & mask);
    endfunction : flag_hit

    // pin synchronisers
    logic [19:0] sync1_q;
    logic [19:0] sync2_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            sync1_q <= 20'h00000;
            sync2_q <= 20'h00000;
        end
        else
        begin
            sync1_q <= {i_precise_freq_monitor_fail, i_guard_soak_timer_fail,
                        i_coarse_freq_monitor_fail, i_cycle_monitor_fail};
            sync2_q <= sync1_q;
        end
    end

    // registers
    logic [2:0]  mode_q;
    logic [3:0]  sel_q;
    logic [7:0]  masks_q;
    logic [3:0]  restore_q;
    logic [4:0]  revert_q;
    logic [7:0]  ranks01_q;
    logic [11:0] ranks24_q;
    trs_state_t  st_q;

    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  idx;
    logic        wr_en;
    logic        auto_mode;

    assign idx               = i_avs_address[9:2];
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_en             = i_avs_write & ack_q;
    assign auto_mode         = (mode_q == MODE_AUTO_NORMAL);

    // failure gating per input
    logic [3:0]     flags   [N];
    logic [N-1:0]   sw_fail;
    logic [N-1:0]   hold_fail;
    logic [N-1:0]   avail_q;
    logic [N-1:0]   qual;
    logic [3:0]     rank    [N];

    always_comb
    begin
        rank[0] = ranks01_q[RANK0_LSB +: 4];
        rank[1] = ranks01_q[RANK1_LSB +: 4];
        rank[2] = ranks24_q[3:0];
        rank[3] = ranks24_q[7:4];
        rank[4] = ranks24_q[11:8];
        for (int n = 0; n < N; n++)
        begin
            flags[n][FLAG_CYCLE]   = sync2_q[n];
            flags[n][FLAG_COARSE]  = sync2_q[5 + n];
            flags[n][FLAG_GUARD]   = sync2_q[10 + n];
            flags[n][FLAG_PRECISE] = sync2_q[15 + n];
            sw_fail[n]   = flag_hit(flags[n], masks_q[SW_MASK_LSB +: 4]);
            hold_fail[n] = flag_hit(flags[n], masks_q[HOLD_MASK_LSB +: 4]);
            qual[n]      = avail_q[n] & ~sw_fail[n];
        end
        if (rank[1] == RANK_DISABLED)
        begin
            qual[1] = 1'b0;
        end
    end

    // restore delay per input
    logic [31:0] cyc_q [N];
    logic [3:0]  min_q [N];

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            avail_q <= '1;
            for (int n = 0; n < N; n++)
            begin
                cyc_q[n] <= 32'h00000000;
                min_q[n] <= 4'h0;
            end
        end
        else
        begin
            for (int n = 0; n < N; n++)
            begin
                if (sw_fail[n] | hold_fail[n])
                begin
                    avail_q[n] <= 1'b0;
                    cyc_q[n]   <= 32'h00000000;
                    min_q[n]   <= 4'h0;
                end
                else if (!avail_q[n])
                begin
                    if (min_q[n] >= restore_q)
                    begin
                        avail_q[n] <= 1'b1;
                    end
                    else if (cyc_q[n] == P_MINUTE_CYCLES - 32'h1)
                    begin
                        cyc_q[n] <= 32'h00000000;
                        min_q[n] <= min_q[n] + 4'h1;
                    end
                    else
                    begin
                        cyc_q[n] <= cyc_q[n] + 32'h1;
                    end
                end
            end
        end
    end

    // best qualified input, lowest code then lowest index
    logic [3:0] best_idx;
    logic       best_ok;
    logic [3:0] best_rank;
    logic       cur_ok;
    logic [3:0] cur_rank;
    logic       all_hold;

    always_comb
    begin
        best_idx  = 4'h0;
        best_ok   = 1'b0;
        best_rank = 4'hF;
        for (int n = 0; n < N; n++)
        begin
            if (auto_mode && qual[n] && (!best_ok || rank[n] < best_rank))
            begin
                best_idx  = 4'(n);
                best_ok   = 1'b1;
                best_rank = rank[n];
            end
        end
        cur_ok   = (sel_q <= SEL_MAX) ? qual[sel_q[2:0]] : 1'b0;
        cur_rank = (sel_q <= SEL_MAX) ? rank[sel_q[2:0]] : 4'hF;
        all_hold = &hold_fail;
    end

    // selection and loop state
    logic revert_now;
    assign revert_now = best_ok && revert_q[best_idx[2:0]] && (best_rank < cur_rank);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            st_q  <= ST_FREERUN;
            sel_q <= RST_REFSEL;
        end
        else
        begin
            case (mode_q)
                MODE_MANUAL_NORMAL:
                begin
                    if (wr_en && idx == IDX_REFSEL && i_avs_byteenable[0])
                    begin
                        sel_q <= i_avs_writedata[3:0];
                    end
                    if (sel_q > SEL_MAX || hold_fail[sel_q[2:0]])
                    begin
                        st_q <= ST_HOLDOVER;
                    end
                    else
                    begin
                        st_q <= ST_LOCKED;
                    end
                end
                MODE_MANUAL_HOLDOVER: st_q <= ST_HOLDOVER;
                MODE_MANUAL_FREERUN:  st_q <= ST_FREERUN;
                MODE_AUTO_NORMAL:
                begin
                    if (!best_ok || all_hold)
                    begin
                        st_q <= ST_HOLDOVER;
                    end
                    else if (st_q != ST_LOCKED || !cur_ok)
                    begin
                        st_q  <= ST_LOCKED;
                        sel_q <= best_idx;
                    end
                    else if (revert_now)
                    begin
                        sel_q <= best_idx;
                    end
                end
                MODE_EXTERNAL:        st_q <= ST_EXTERNAL;
                default:              st_q <= ST_FREERUN;
            endcase
        end
    end

    // configuration writes
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            mode_q    <= RST_MODE;
            masks_q   <= RST_FAIL_MASKS;
            restore_q <= RST_RESTORE;
            revert_q  <= RST_REVERT;
            ranks01_q <= RST_RANKS01;
            ranks24_q <= RST_RANKS24;
        end
        else if (wr_en && i_avs_byteenable[0])
        begin
            case (idx)
                IDX_MODE:       mode_q    <= i_avs_writedata[2:0];
                IDX_FAIL_MASKS: masks_q   <= i_avs_writedata[7:0];
                IDX_RESTORE:    restore_q <= i_avs_writedata[3:0];
                IDX_REVERT:     revert_q  <= i_avs_writedata[4:0];
                IDX_RANKS01:    ranks01_q <= i_avs_writedata[7:0];
                IDX_RANKS24:
                begin
                    ranks24_q[7:0] <= i_avs_writedata[7:0];
                    if (i_avs_byteenable[1])
                    begin
                        ranks24_q[11:8] <= i_avs_writedata[11:8];
                    end
                end
                default:        mode_q    <= mode_q;
            endcase
        end
    end

    // bus handshake and read data, answer one cycle after the request
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
            if (i_avs_read && !ack_q)
            begin
                case (idx)
                    IDX_MODE:       rdata_q <= {29'h0, mode_q};
                    IDX_REFSEL:     rdata_q <= {28'h0, sel_q};
                    IDX_FAIL_MASKS: rdata_q <= {24'h0, masks_q};
                    IDX_RESTORE:    rdata_q <= {28'h0, restore_q};
                    IDX_REVERT:     rdata_q <= {27'h0, revert_q};
                    IDX_RANKS01:    rdata_q <= {24'h0, ranks01_q};
                    IDX_RANKS24:    rdata_q <= {20'h0, ranks24_q};
                    IDX_STATUS:     rdata_q <= {17'h0, hold_fail, sw_fail, avail_q};
                    default:        rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign o_avs_readdata     = rdata_q;
    assign o_selected_input   = sel_q;
    assign o_locked           = (st_q == ST_LOCKED);
    assign o_holdover         = (st_q == ST_HOLDOVER);
    assign o_freeze_estimate  = (st_q == ST_HOLDOVER);
    assign o_freerun          = (st_q == ST_FREERUN);
    assign o_external_control = (st_q == ST_EXTERNAL);

    // checks
    AST_SW_MASK_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (masks_q[3:0] == 4'h0) |-> (sw_fail == 5'h00))
        else $error("switch fail seen with all switch mask bits clear");

    AST_HOLD_MASK_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (masks_q[7:4] == 4'h0) |-> (hold_fail == 5'h00))
        else $error("holdover fail seen with all holdover mask bits clear");

    AST_FAIL_DROPS_AVAIL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (sw_fail[0] || hold_fail[0]) |=> !avail_q[0] && min_q[0] == 4'h0)
        else $error("failed input still marked available");

    AST_RESTORE_EARLY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(avail_q[2]) |-> $past(min_q[2]) >= $past(restore_q))
        else $error("input restored before its delay ran out");

    AST_INPUT1_EXCLUDED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (ranks01_q[7:4] == 4'hF) |-> !qual[1] && !(best_ok && best_idx == 4'h1))
        else $error("disabled input one is a candidate");

    AST_SWITCH_AWAY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (auto_mode && st_q == ST_LOCKED && !cur_ok && best_ok && !all_hold)
        |=> sel_q == $past(best_idx) && st_q == ST_LOCKED)
        else $error("no switch to best input after failure");

    AST_NONE_LEFT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (auto_mode && !best_ok) |=> o_holdover && o_freeze_estimate)
        else $error("no holdover with no qualified input");

    AST_ALL_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (auto_mode && all_hold) |=> st_q == ST_HOLDOVER ##0 $stable(sel_q))
        else $error("holdover not entered when all inputs fail");

    AST_REVERT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (auto_mode && st_q == ST_LOCKED && cur_ok && !all_hold && revert_now)
        |=> sel_q == $past(best_idx))
        else $error("revertive input not taken back");

    AST_NO_REVERT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (auto_mode && st_q == ST_LOCKED && cur_ok && !all_hold && !revert_now)
        |=> $stable(sel_q))
        else $error("selection moved without cause");

    AST_MANUAL_SEL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_q == MODE_MANUAL_NORMAL && wr_en && idx == IDX_REFSEL && i_avs_byteenable[0])
        |=> sel_q == $past(i_avs_writedata[3:0]))
        else $error("manual selector write lost");

    AST_BUS_ANSWER: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

endmodule : trs_ref_switch

`default_nettype wire

// ===== core/trs_pkg.sv
// package: register map, field layout, reset values and timing of the reference switch block
package trs_pkg;

    localparam int unsigned NUM_INPUTS = 5;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_MODE       = 8'h1F;
    localparam logic [7:0] IDX_REFSEL     = 8'h20;
    localparam logic [7:0] IDX_FAIL_MASKS = 8'h21;
    localparam logic [7:0] IDX_RESTORE    = 8'h22;
    localparam logic [7:0] IDX_REVERT     = 8'h23;
    localparam logic [7:0] IDX_RANKS01    = 8'h24;
    localparam logic [7:0] IDX_RANKS24    = 8'h30;
    localparam logic [7:0] IDX_STATUS     = 8'h31;

    // reset values
    localparam logic [2:0]  RST_MODE       = 3'h0;
    localparam logic [3:0]  RST_REFSEL     = 4'h0;
    localparam logic [7:0]  RST_FAIL_MASKS = 8'h3C;
    localparam logic [3:0]  RST_RESTORE    = 4'h0;
    localparam logic [4:0]  RST_REVERT     = 5'h00;
    localparam logic [7:0]  RST_RANKS01    = 8'h10;
    localparam logic [11:0] RST_RANKS24    = 12'h432;

    // field positions
    localparam int unsigned SW_MASK_LSB   = 0;
    localparam int unsigned HOLD_MASK_LSB = 4;
    localparam int unsigned RANK0_LSB     = 0;
    localparam int unsigned RANK1_LSB     = 4;

    // failure indicator order inside a mask nibble
    localparam int unsigned FLAG_CYCLE   = 0;
    localparam int unsigned FLAG_COARSE  = 1;
    localparam int unsigned FLAG_GUARD   = 2;
    localparam int unsigned FLAG_PRECISE = 3;

    localparam logic [3:0] RANK_DISABLED = 4'hF;
    localparam logic [3:0] SEL_MAX       = 4'h4;

    // timing of the restore delay
    localparam int unsigned    MINUTE_SECONDS = 60;
    localparam int unsigned    REF_CLK_HZ     = 25_000_000;
    localparam longint unsigned MINUTE_CYCLES =
        longint'(MINUTE_SECONDS) * longint'(REF_CLK_HZ);

    typedef enum logic [2:0]
    {
        MODE_MANUAL_NORMAL,
        MODE_MANUAL_HOLDOVER,
        MODE_MANUAL_FREERUN,
        MODE_AUTO_NORMAL,
        MODE_EXTERNAL
    } trs_mode_t;

    typedef enum logic [1:0]
    {
        ST_FREERUN,
        ST_LOCKED,
        ST_HOLDOVER,
        ST_EXTERNAL
    } trs_state_t;

endpackage : trs_pkg

// ===== tb/tb_top.sv
// self-checking bench for the reference switch block
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import trs_pkg::*;
();
    typedef struct {logic wr; logic [7:0] idx; logic [31:0] wd; logic [31:0] exp;} trs_row_t;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [4:0]  f_cyc = 5'h00;
    logic [4:0]  f_crs = 5'h00;
    logic [4:0]  f_grd = 5'h00;
    logic [4:0]  f_prc = 5'h00;
    logic [3:0]  sel;
    logic        locked;
    logic        holdover;
    logic        freeze;
    logic        freerun;
    logic        ext_ctl;
    logic [31:0] rd_q;
    int          err_total = 0;
    int          n_tests = 0;

    // first six rows read reset values, then write and read back, last four cover ranks24 and status
    trs_row_t rows [19] = '{
        '{1'b0, 8'h21, 32'h0, 32'h3C}, '{1'b0, 8'h22, 32'h0, 32'h00},
        '{1'b0, 8'h23, 32'h0, 32'h00}, '{1'b0, 8'h24, 32'h0, 32'h10},
        '{1'b0, 8'h20, 32'h0, 32'h00}, '{1'b0, 8'h05, 32'h0, 32'h00},
        '{1'b1, 8'h21, 32'hA5, 32'hA5}, '{1'b1, 8'h22, 32'hFF, 32'h0F},
        '{1'b1, 8'h23, 32'hFF, 32'h1F}, '{1'b1, 8'h24, 32'hE7, 32'hE7},
        '{1'b1, 8'h05, 32'hFF, 32'h00}, '{1'b1, 8'h21, 32'h3C, 32'h3C},
        '{1'b1, 8'h22, 32'h00, 32'h00}, '{1'b1, 8'h23, 32'h00, 32'h00},
        '{1'b1, 8'h24, 32'h10, 32'h10},
        '{1'b0, 8'h30, 32'h0, 32'h432}, '{1'b0, 8'h31, 32'h0, 32'h1F},
        '{1'b1, 8'h30, 32'h765, 32'h765}, '{1'b1, 8'h30, 32'h432, 32'h432}
    };

    always #20 ref_clk = ~ref_clk;

    trs_ref_switch #(.P_MINUTE_CYCLES(32'd8)) i_trs_ref_switch (
        .i_ref_clk                   (ref_clk),
        .i_rst_n                     (rst_n),
        .i_avs_address               (avs_address),
        .i_avs_read                  (avs_read),
        .i_avs_write                 (avs_write),
        .i_avs_writedata             (avs_writedata),
        .i_avs_byteenable            (avs_byteenable),
        .o_avs_readdata              (avs_readdata),
        .o_avs_waitrequest           (avs_waitrequest),
        .i_cycle_monitor_fail        (f_cyc),
        .i_coarse_freq_monitor_fail  (f_crs),
        .i_guard_soak_timer_fail     (f_grd),
        .i_precise_freq_monitor_fail (f_prc),
        .o_selected_input            (sel),
        .o_locked                    (locked),
        .o_holdover                  (holdover),
        .o_freeze_estimate           (freeze),
        .o_freerun                   (freerun),
        .o_external_control          (ext_ctl)
    );

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        @(posedge ref_clk);
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= wd;
        // sample waitrequest at the rising edge; write lands and read data is taken there
        for (k = 0; k < 20; k++)
        begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (k == 20)
        begin
            err_total++;
            wrap_up();
        end
        rd_q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : settle

    task automatic wait_sel(input logic [3:0] exp);
        int k;
        for (k = 0; k < 60; k++)
        begin
            @(negedge ref_clk);
            if (sel === exp)
                break;
        end
        chk({28'h0, sel}, {28'h0, exp});
        if (k == 60)
            wrap_up();
    endtask : wait_sel

    // drive one failure kind on the given inputs, the others low
    task automatic set_flag(input int kind, input logic [4:0] v);
        @(posedge ref_clk);
        f_cyc <= (kind == FLAG_CYCLE)   ? v : 5'h00;
        f_crs <= (kind == FLAG_COARSE)  ? v : 5'h00;
        f_grd <= (kind == FLAG_GUARD)   ? v : 5'h00;
        f_prc <= (kind == FLAG_PRECISE) ? v : 5'h00;
    endtask : set_flag

    initial
    begin
        #(40 * 20000);
        $display("watchdog expired");
        err_total++;
        wrap_up();
    end

    initial
    begin
        settle(6);
        rst_n <= 1'b1;
        settle(2);
        foreach (rows[r])
        begin
            if (rows[r].wr)
                bus(1'b1, rows[r].idx, rows[r].wd);
            bus(1'b0, rows[r].idx, 32'h0);
            chk(rd_q, rows[r].exp);
        end
        $display("register rows done");
        chk({31'h0, locked}, 32'h1);
        set_flag(FLAG_CYCLE, 5'h01);
        settle(5);
        chk({30'h0, holdover, freeze}, 32'h3);
        set_flag(FLAG_CYCLE, 5'h00);
        settle(5);
        chk({31'h0, locked}, 32'h1);
        bus(1'b1, IDX_FAIL_MASKS, 32'h2C);
        set_flag(FLAG_CYCLE, 5'h01);
        settle(5);
        chk({31'h0, locked}, 32'h1);
        set_flag(FLAG_CYCLE, 5'h00);
        bus(1'b1, IDX_REFSEL, 32'h2);
        settle(2);
        chk({28'h0, sel}, 32'h2);
        bus(1'b1, IDX_REFSEL, 32'h0);
        $display("manual mode done");
        bus(1'b1, IDX_REVERT, 32'h01);
        bus(1'b1, IDX_MODE, 32'h3);
        wait_sel(4'h0);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, IDX_FAIL_MASKS, 32'(1 << k));
            set_flag((k + 1) % 4, 5'h01);
            settle(6);
            chk({28'h0, sel}, 32'h0);
            set_flag(k, 5'h01);
            wait_sel(4'h1);
            set_flag(k, 5'h00);
            wait_sel(4'h0);
        end
        bus(1'b1, IDX_FAIL_MASKS, 32'h3C);
        set_flag(FLAG_GUARD, 5'h01);
        wait_sel(4'h1);
        bus(1'b1, IDX_REFSEL, 32'h3);
        bus(1'b0, IDX_REFSEL, 32'h0);
        chk(rd_q, 32'h1);
        bus(1'b1, IDX_REVERT, 32'h00);
        bus(1'b1, IDX_RESTORE, 32'h1);
        set_flag(FLAG_GUARD, 5'h00);
        settle(20);
        chk({28'h0, sel}, 32'h1);
        bus(1'b1, IDX_REVERT, 32'h01);
        wait_sel(4'h0);
        set_flag(FLAG_GUARD, 5'h01);
        wait_sel(4'h1);
        set_flag(FLAG_GUARD, 5'h00);
        settle(8);
        chk({28'h0, sel}, 32'h1);
        wait_sel(4'h0);
        $display("automatic switching done");
        set_flag(FLAG_CYCLE, 5'h1F);
        settle(5);
        chk({30'h0, holdover, freeze}, 32'h3);
        bus(1'b1, IDX_RANKS01, 32'hF1);
        set_flag(FLAG_CYCLE, 5'h1D);
        settle(14);
        chk({31'h0, holdover}, 32'h1);
        set_flag(FLAG_CYCLE, 5'h1F);
        bus(1'b1, IDX_RANKS01, 32'h01);
        set_flag(FLAG_CYCLE, 5'h00);
        wait_sel(4'h1);
        chk({31'h0, locked}, 32'h1);
        $display("holdover and ranks done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        settle(2);
        chk({30'h0, freerun, locked}, 32'h2);
        rst_n <= 1'b1;
        settle(2);
        bus(1'b0, IDX_FAIL_MASKS, 32'h0);
        chk(rd_q, 32'h3C);
        bus(1'b0, IDX_RANKS01, 32'h0);
        chk(rd_q, 32'h10);
        @(posedge ref_clk);
        avs_byteenable <= 4'hE;
        bus(1'b1, IDX_FAIL_MASKS, 32'h00);
        avs_byteenable <= 4'hF;
        bus(1'b0, IDX_FAIL_MASKS, 32'h0);
        chk(rd_q, 32'h3C);
        bus(1'b1, IDX_REFSEL, 32'h5);
        settle(2);
        chk({31'h0, holdover}, 32'h1);
        bus(1'b1, IDX_REFSEL, 32'h0);
        bus(1'b1, IDX_MODE, 32'h1);
        settle(2);
        chk({30'h0, holdover, freeze}, 32'h3);
        bus(1'b1, IDX_MODE, 32'h2);
        settle(2);
        chk({31'h0, freerun}, 32'h1);
        bus(1'b1, IDX_MODE, 32'h4);
        settle(2);
        chk({31'h0, ext_ctl}, 32'h1);
        $display("second reset done");
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
